// [cfg_access.sv]
`timescale 1ns/1ps
// Contract
// - strap sampled just after reset release picks path: 00 eeprom load, 01 i2c slave, 10 spi slave
// - without eeprom the registers keep defaults, register 1 taken from strap levels
// - eeprom load fills registers 0 to 120 in order, skipping read-only ones
// - first eeprom byte must equal family id, else everything is ignored
// - i2c slave answers device bytes 1011_1111 read and 1011_1110 write
// - i2c slave uses address byte then data like a small serial eeprom
// - both slaves reach all 198 registers; tables go through 121 to 131
// - spi command 0000_0011 reads, 0000_0010 writes
// - read burst continues with next register while select stays low
// - write burst stores into next register while select stays low
// - burst address wraps to zero after the last register
// - spi data out launched on falling clock, input captured on rising
// - registers may be rewritten while the switch runs, no restart
module cfg_access
  import cfg_access_pkg::*;
#(
  parameter logic [7:0]                 family_id     = 8'h5a, // arbitrary value
  parameter logic [REG_COUNT-1:0]       ro_mask       = '0,
  parameter logic [REG_COUNT-1:0][7:0]  reg_defaults  = '0,
  parameter int                         quarter_cycles = SCL_QUARTER_CYC
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic [1:0]                config_mode_strap,
  input  wire logic [7:0]                strap_levels,
  input  wire logic                      power_down_in_n,
  input  wire logic                      serial_slave_select_n,
  input  wire logic                      serial_clock_in,
  input  wire logic                      serial_data_in,
  output logic                           serial_data_out,
  input  wire logic                      scl_in,
  output logic                           scl_out,
  output logic                           scl_oe,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  output cfg_access_pkg::mode_t          mode,
  output logic [REG_COUNT-1:0][7:0]      config_regs
);
  import cfg_access_pkg::*;

  // the bit divider is 16 bits wide, so longer quarters cannot be counted
  if (quarter_cycles < 2 || quarter_cycles > 65536 || REG_COUNT > 256) begin : g_check
    $error("cfg_access: unsupported parameters");
  end

  // ==========================================================
  // pin synchronisers and boot capture
  logic [PIN_COUNT-1:0] sync1, sync2, prev;
  logic [1:0]           boot_cnt;
  logic                 booted;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '1;
      sync2 <= '1;
      prev  <= '1;
    end else begin
      sync1 <= {power_down_in_n, sda_in, scl_in, serial_data_in,
                serial_clock_in, serial_slave_select_n};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end
  // strap is a level caught after release, never under the reset itself
  logic [1:0] strap_s1, strap_s2;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_s1 <= 2'h3;
      strap_s2 <= 2'h3;
      boot_cnt <= 2'h0;
      booted   <= 1'b0;
      mode     <= MODE_OFF;
    end else begin
      strap_s1 <= config_mode_strap;
      strap_s2 <= strap_s1;
      if (!booted) boot_cnt <= boot_cnt + 2'h1;
      if (boot_cnt == BOOT_CAPTURE) begin
        mode   <= mode_t'(strap_s2);
        booted <= 1'b1;
      end
    end
  end
  logic [7:0] lvl_s1, lvl_s2;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_s1 <= 8'h00;
      lvl_s2 <= 8'h00;
    end else begin
      lvl_s1 <= strap_levels;
      lvl_s2 <= lvl_s1;
    end
  end
  wire sck_rise = sync2[PIN_SCK] & ~prev[PIN_SCK];
  wire sck_fall = ~sync2[PIN_SCK] & prev[PIN_SCK];
  wire ss_low   = ~sync2[PIN_SS];
  wire scl_rise = sync2[PIN_SCL] & ~prev[PIN_SCL];
  wire scl_fall = ~sync2[PIN_SCL] & prev[PIN_SCL];
  wire i2c_start = sync2[PIN_SCL] & prev[PIN_SCL] & prev[PIN_SDA] & ~sync2[PIN_SDA];
  wire i2c_stop  = sync2[PIN_SCL] & prev[PIN_SCL] & ~prev[PIN_SDA] & sync2[PIN_SDA];

  // ==========================================================
  // register file: single write port, any time after boot
  reg_write_t ee_wr, i2c_wr, spi_wr;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      config_regs <= reg_defaults;
    end else if (boot_cnt == BOOT_CAPTURE && !booted) begin
      config_regs[STRAP_REG] <= lvl_s2;
    end else if (ee_wr.en) begin
      config_regs[ee_wr.addr] <= ee_wr.data;
    end else if (i2c_wr.en) begin
      config_regs[i2c_wr.addr] <= i2c_wr.data;
    end else if (spi_wr.en) begin
      config_regs[spi_wr.addr] <= spi_wr.data;
    end
  end

  // ==========================================================
  // spi slave
  logic [1:0] spi_phase;
  logic [2:0] spi_bit;
  logic [7:0] spi_shift, spi_cmd, spi_addr, spi_tx;
  wire  [7:0] spi_byte = {spi_shift[6:0], sync2[PIN_MOSI]};
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      spi_phase <= 2'h0;
      spi_bit   <= 3'h0;
      spi_shift <= 8'h00;
      spi_cmd   <= 8'h00;
      spi_addr  <= 8'h00;
      spi_tx    <= 8'h00;
      spi_wr    <= '0;
      serial_data_out <= 1'b0;
    end else begin
      spi_wr.en <= 1'b0;
      if (mode != MODE_SPI || !ss_low) begin
        spi_phase <= 2'h0;
        spi_bit   <= 3'h0;
      end else if (sck_rise) begin
        spi_shift <= spi_byte;
        spi_bit   <= spi_bit + 3'h1;
        if (spi_bit == 3'h7) begin
          if (spi_phase != 2'h2) spi_phase <= spi_phase + 2'h1;
          unique case (spi_phase)
            2'h0: spi_cmd <= spi_byte;
            2'h1: begin
              spi_addr <= (spi_byte < 8'(REG_COUNT)) ? spi_byte : 8'h00;
              spi_tx   <= config_regs[(spi_byte < 8'(REG_COUNT)) ? spi_byte : 8'h00];
            end
            default: begin
              if (spi_cmd == SPI_CMD_WR) begin
                spi_wr <= '{en: 1'b1, addr: spi_addr, data: spi_byte};
              end
              spi_addr <= next_addr(spi_addr);
              spi_tx   <= config_regs[next_addr(spi_addr)];
            end
          endcase
        end
      end else if (sck_fall && spi_phase == 2'h2 && spi_cmd == SPI_CMD_RD) begin
        serial_data_out <= spi_tx[7];
        spi_tx          <= {spi_tx[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // i2c slave
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_RX = 3'h1, S_ACK = 3'h3, S_TX = 3'h2, S_MACK = 3'h6
  } slv_t;
  slv_t       slv;
  logic [1:0] slv_phase;
  logic [3:0] slv_bit;
  logic [7:0] slv_shift, slv_addr;
  logic       slv_read, slv_low;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      slv       <= S_IDLE;
      slv_phase <= 2'h0;
      slv_bit   <= 4'h0;
      slv_shift <= 8'h00;
      slv_addr  <= 8'h00;
      slv_read  <= 1'b0;
      slv_low   <= 1'b0;
      i2c_wr    <= '0;
    end else begin
      i2c_wr.en <= 1'b0;
      if (mode != MODE_I2C || i2c_stop) begin
        slv     <= S_IDLE;
        slv_low <= 1'b0;
      end else if (i2c_start) begin
        slv       <= S_RX;
        slv_phase <= 2'h0;
        slv_bit   <= 4'h0;
        slv_low   <= 1'b0;
      end else begin
        unique case (slv)
          S_IDLE: ;
          S_RX: if (scl_rise) begin
            slv_shift <= {slv_shift[6:0], sync2[PIN_SDA]};
            slv_bit   <= slv_bit + 4'h1;
          end else if (scl_fall && slv_bit == 4'h8) begin
            slv_bit <= 4'h0;
            slv     <= S_ACK;
            slv_low <= 1'b1;
            unique case (slv_phase)
              2'h0: begin
                slv_read  <= (slv_shift == I2C_DEV_RD);
                slv_phase <= 2'h1;
                if (slv_shift != I2C_DEV_RD && slv_shift != I2C_DEV_WR) begin
                  slv     <= S_IDLE;
                  slv_low <= 1'b0;
                end
              end
              2'h1: begin
                slv_addr  <= (slv_shift < 8'(REG_COUNT)) ? slv_shift : 8'h00;
                slv_phase <= 2'h2;
              end
              default: begin
                i2c_wr   <= '{en: 1'b1, addr: slv_addr, data: slv_shift};
                slv_addr <= next_addr(slv_addr);
              end
            endcase
          end
          S_ACK: if (scl_fall) begin
            if (slv_read) begin
              slv       <= S_TX;
              slv_shift <= {config_regs[slv_addr][6:0], 1'b0};
              slv_low   <= ~config_regs[slv_addr][7];
            end else begin
              slv     <= S_RX;
              slv_low <= 1'b0;
            end
          end
          S_TX: if (scl_fall) begin
            slv_bit   <= slv_bit + 4'h1;
            slv_low   <= (slv_bit != 4'h7) & ~slv_shift[7];
            slv_shift <= {slv_shift[6:0], 1'b0};
            if (slv_bit == 4'h7) slv <= S_MACK;
          end
          S_MACK: if (scl_rise) begin
            slv_bit  <= 4'h0;
            slv_addr <= next_addr(slv_addr);
            slv      <= sync2[PIN_SDA] ? S_IDLE : S_ACK;
          end
          default: slv <= S_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // eeprom loader, i2c master
  typedef enum logic [2:0] {
    M_WAIT = 3'h0, M_START = 3'h1, M_SEND = 3'h3, M_RSTART = 3'h2,
    M_RECV = 3'h6, M_STOP = 3'h7, M_DONE = 3'h5
  } mst_t;
  mst_t        mst;
  logic [15:0] div;
  logic [1:0]  q, step;
  logic [3:0]  mbit;
  logic [7:0]  mshift, midx;
  logic        m_scl, m_sda, nack;
  wire         tick = (div == 16'(quarter_cycles - 1));
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) div <= 16'h0000;
    else        div <= tick ? 16'h0000 : div + 16'h0001;
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mst <= M_WAIT;
      q <= 2'h0; step <= 2'h0; mbit <= 4'h0;
      mshift <= 8'h00; midx <= 8'h00; nack <= 1'b0;
      m_scl <= 1'b1; m_sda <= 1'b1;
      ee_wr <= '0;
    end else begin
      ee_wr.en <= 1'b0;
      if (tick) begin
        q <= q + 2'h1;
        unique case (mst)
          M_WAIT: begin
            q <= 2'h0;
            if (booted && mode == MODE_EEPROM && sync2[PIN_PWR]) mst <= M_START;
          end
          M_START, M_RSTART: unique case (q)
            2'h0: begin m_sda <= 1'b1; m_scl <= (mst == M_START); end
            2'h1: if (mst == M_START) m_sda <= 1'b0; else m_scl <= 1'b1;
            2'h2: if (mst == M_START) m_scl <= 1'b0; else m_sda <= 1'b0;
            default: begin
              if (mst == M_RSTART) m_scl <= 1'b0;
              mst    <= M_SEND;
              mbit   <= 4'h0;
              mshift <= (mst == M_START) ? EEPROM_DEV_WR : EEPROM_DEV_RD;
              step   <= (mst == M_START) ? 2'h0 : 2'h2;
            end
          endcase
          M_SEND, M_RECV: unique case (q)
            2'h0: begin
              if (mst == M_SEND) m_sda <= (mbit == 4'h8) | mshift[7];
              else begin
                nack  <= (midx == 8'(LOAD_BYTES - 1)) || (midx == 8'h00 && mshift != family_id);
                m_sda <= (mbit != 4'h8) | (midx == 8'(LOAD_BYTES - 1))
                         | (midx == 8'h00 && mshift != family_id);
              end
            end
            2'h1: m_scl <= 1'b1;
            2'h2: if (mst == M_RECV && mbit != 4'h8) mshift <= {mshift[6:0], sync2[PIN_SDA]};
            default: begin
              m_scl <= 1'b0;
              mbit  <= mbit + 4'h1;
              if (mst == M_SEND) mshift <= {mshift[6:0], 1'b0};
              if (mbit == 4'h8) begin
                mbit <= 4'h0;
                if (mst == M_SEND) begin
                  step   <= step + 2'h1;
                  mshift <= EEPROM_START;
                  mst    <= (step == 2'h0) ? M_SEND : (step == 2'h1) ? M_RSTART : M_RECV;
                end else begin
                  midx <= midx + 8'h01;
                  if (midx != 8'h00 && !ro_mask[midx - 8'h01]) begin
                    ee_wr <= '{en: 1'b1, addr: midx - 8'h01, data: mshift};
                  end
                  if (nack) mst <= M_STOP;
                end
              end
            end
          endcase
          M_STOP: unique case (q)
            2'h0: m_sda <= 1'b0;
            2'h1: m_scl <= 1'b1;
            2'h2: m_sda <= 1'b1;
            default: mst <= M_DONE;
          endcase
          M_DONE: q <= 2'h0;
          default: mst <= M_WAIT;
        endcase
      end
    end
  end

  // ==========================================================
  // open-drain pins: only ever pull low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      scl_oe <= (mode == MODE_EEPROM) & ~m_scl;
      sda_oe <= (mode == MODE_EEPROM) ? ~m_sda : (mode == MODE_I2C) & slv_low;
    end
  end

  // ==========================================================
  mode_stable_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    booted && $past(booted) |-> $stable(mode)) else $error("mode changed after boot");
  id_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ee_wr.en |-> midx >= 8'h02 && !ro_mask[ee_wr.addr]) else $error("eeprom write bad");
  load_range_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ee_wr.en |-> ee_wr.addr <= 8'(LOAD_LAST_REG)) else $error("eeprom load overrun");
  spi_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    spi_wr.en |-> spi_cmd == SPI_CMD_WR && $past(sck_rise)) else $error("spi write w/o cmd");
  addr_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    spi_addr < 8'(REG_COUNT) && slv_addr < 8'(REG_COUNT)) else $error("address past end");
  dev_match_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    slv == S_RX && slv_phase == 2'h0 && scl_fall && slv_bit == 4'h8
    && slv_shift != I2C_DEV_RD && slv_shift != I2C_DEV_WR && !i2c_start && !i2c_stop
    |=> slv == S_IDLE && !slv_low) else $error("foreign i2c address acked");
  miso_launch_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(serial_data_out) |-> $past(sck_fall)) else $error("miso moved off falling edge");
  burst_end_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !ss_low |=> spi_phase == 2'h0) else $error("burst outlived select");
  pwr_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    mst == M_WAIT ##1 mst == M_START |-> $past(sync2[PIN_PWR])) else $error("load in power down");
endmodule : cfg_access

// [cfg_access_pkg.sv]
package cfg_access_pkg;
  // ==========================================================
  // register space
  localparam int         REG_COUNT       = 198;
  localparam int         LOAD_LAST_REG   = 120;
  localparam int         LOAD_BYTES      = LOAD_LAST_REG + 2;
  localparam logic [7:0] STRAP_REG       = 8'h01;
  // ==========================================================
  // serial command and address codes
  localparam logic [7:0] I2C_DEV_RD      = 8'hbf;
  localparam logic [7:0] I2C_DEV_WR      = 8'hbe;
  localparam logic [7:0] SPI_CMD_RD      = 8'h03;
  localparam logic [7:0] SPI_CMD_WR      = 8'h02;
  localparam logic [7:0] EEPROM_DEV_WR   = 8'ha0;
  localparam logic [7:0] EEPROM_DEV_RD   = 8'ha1;
  localparam logic [7:0] EEPROM_START    = 8'h00;
  // ==========================================================
  // timing
  localparam int         CLK_PERIOD_NS   = 20;
  localparam int         SCL_QUARTER_NS  = 2500;
  localparam int         SCL_QUARTER_CYC = SCL_QUARTER_NS / CLK_PERIOD_NS;
  localparam logic [1:0] BOOT_CAPTURE    = 2'h2;
  // ==========================================================
  // synchronised pin vector
  localparam int         PIN_SS          = 0;
  localparam int         PIN_SCK         = 1;
  localparam int         PIN_MOSI        = 2;
  localparam int         PIN_SCL         = 3;
  localparam int         PIN_SDA         = 4;
  localparam int         PIN_PWR         = 5;
  localparam int         PIN_COUNT       = 6;
  // ==========================================================
  typedef enum logic [1:0] {
    MODE_EEPROM = 2'h0, MODE_I2C = 2'h1, MODE_SPI = 2'h2, MODE_OFF = 2'h3
  } mode_t;
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;
  function automatic logic [7:0] next_addr(input logic [7:0] a);
    return (a == 8'(REG_COUNT - 1)) ? 8'h00 : a + 8'h01;
  endfunction : next_addr
endpackage : cfg_access_pkg

// [cfg_access_test.sv]
`timescale 1ns/1ps
module cfg_access_test;
  import cfg_access_pkg::*;
  localparam logic [REG_COUNT-1:0] RO = 198'h82;
  localparam logic [7:0]           ID = 8'h5a; // arbitrary value
  logic                      core_clk, rst_b, power_down_in_n, ss_n, sck, mosi;
  logic [1:0]                config_mode_strap;
  logic [7:0]                strap_levels, rx, wd;
  logic                      miso, scl_oe, sda_oe, ee_oe;
  logic                      i2c_scl_low, i2c_sda_low, ack;
  mode_t                     mode;
  logic [REG_COUNT-1:0][7:0] config_regs;
  wire                       scl = ~(scl_oe | i2c_scl_low);
  wire                       sda = ~(sda_oe | ee_oe | i2c_sda_low);
  int                        exp_regs[REG_COUNT];
  int                        miscompares, n_tests, a;

  cfg_access #(.family_id(ID), .ro_mask(RO), .quarter_cycles(4)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .config_mode_strap(config_mode_strap),
    .strap_levels(strap_levels), .power_down_in_n(power_down_in_n),
    .serial_slave_select_n(ss_n), .serial_clock_in(sck), .serial_data_in(mosi),
    .serial_data_out(miso), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .mode(mode), .config_regs(config_regs));
  cfg_eeprom_model pm (.scl(scl), .sda(sda), .sda_oe(ee_oe));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ==========================================================
  // helpers
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task chk(input logic [7:0] seen, input logic [7:0] expv);
    n_tests++;
    if (seen !== expv) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, expv);
    end
  endtask : chk
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task cmp_all;
    foreach (exp_regs[i]) chk(config_regs[i], 8'(exp_regs[i]));
  endtask : cmp_all
  task boot(input logic [1:0] s);
    rst_b = 1'b0;
    power_down_in_n = 1'b1;
    config_mode_strap = s;
    strap_levels = 8'($urandom);
    cyc(16);
    rst_b = 1'b1;
    // loader must wait while power-down is low after release
    power_down_in_n = (s != 2'h0);
    cyc(8);
    foreach (exp_regs[i]) exp_regs[i] = 0;
    exp_regs[1] = strap_levels;
    chk({6'h00, mode}, {6'h00, s});
    chk(config_regs[1], strap_levels);
  endtask : boot
  // ==========================================================
  // spi master, idle clock low, sample just before the next fall
  task spi_byte(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      mosi = tx[i];
      cyc(4);
      sck = 1'b1;
      cyc(4);
      rx[i] = miso;
    end
  endtask : spi_byte
  task spi_wr(input logic [7:0] cmd, input int ad, input int n, input bit take);
    logic [7:0] d;
    ss_n = 1'b0;
    cyc(4);
    spi_byte(cmd);
    spi_byte(8'(ad));
    repeat (n) begin
      d = 8'($urandom);
      spi_byte(d);
      if (take) exp_regs[ad] = d;
      ad = (ad + 1) % REG_COUNT;
    end
    sck = 1'b0;
    cyc(4);
    ss_n = 1'b1;
    mosi = ~mosi;
    cyc(8);
  endtask : spi_wr
  task spi_rd(input int ad, input int n);
    ss_n = 1'b0;
    cyc(4);
    spi_byte(SPI_CMD_RD);
    spi_byte(8'(ad));
    repeat (n) begin
      spi_byte(8'h00);
      chk(rx, 8'(exp_regs[ad]));
      ad = (ad + 1) % REG_COUNT;
    end
    sck = 1'b0;
    cyc(4);
    ss_n = 1'b1;
    cyc(8);
  endtask : spi_rd
  // ==========================================================
  // two-wire master, open drain, eight clocks a quarter
  // quarters this long leave the slave's sync and drive delay well inside scl low
  task i2c_bit(input bit b, output logic r);
    i2c_sda_low = ~b;
    cyc(8);
    i2c_scl_low = 1'b0;
    cyc(8);
    r = sda;
    i2c_scl_low = 1'b1;
    cyc(8);
  endtask : i2c_bit
  // start when stop is 0, stop when stop is 1; sda may first set up with scl low, the condition edge comes with scl high
  task i2c_cond(input bit stop);
    i2c_sda_low = stop;
    cyc(8);
    i2c_scl_low = 1'b0;
    cyc(8);
    i2c_sda_low = ~stop;
    cyc(8);
    i2c_scl_low = ~stop;
    cyc(8);
  endtask : i2c_cond
  task i2c_tx(input logic [7:0] b, output logic got);
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], got);
    i2c_bit(1'b1, got);
  endtask : i2c_tx
  task i2c_rx(input bit last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) i2c_bit(1'b1, b[i]);
    i2c_bit(last, r);
  endtask : i2c_rx
  // ==========================================================
  // eeprom load with power-down held low for a while first
  task ee_load(input logic [7:0] id);
    int quiet, t;
    pm.mem[0] = id;
    for (int n = 1; n < LOAD_BYTES; n++) pm.mem[n] = 8'($urandom);
    boot(2'h0);
    t = 0;
    repeat (100) begin
      cyc(1);
      if (scl_oe !== 1'b0) t++;
    end
    chk(8'(t), 8'h00);
    power_down_in_n = 1'b1;
    quiet = 0;
    for (t = 0; t < 40000 && quiet < 300; t++) begin
      cyc(1);
      quiet = (scl_oe === 1'b0 && sda_oe === 1'b0) ? quiet + 1 : 0;
    end
    if (quiet < 300) begin
      miscompares++;
      $display("unexpected at %0t: loader never went quiet", $time);
      summarize();
    end
    if (id == ID) begin
      for (int n = 0; n <= LOAD_LAST_REG; n++)
        if (!RO[n]) exp_regs[n] = pm.mem[n+1];
    end
    cmp_all();
    $display("test eeprom load id %h done", id);
  endtask : ee_load
  // ==========================================================
  initial begin
    rst_b = 1'b0;
    power_down_in_n = 1'b1;
    ss_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    i2c_scl_low = 1'b0;
    i2c_sda_low = 1'b0;
    config_mode_strap = 2'h2;
    strap_levels = 8'h00;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(85));
    boot(2'h2);
    cmp_all();
    $display("test spi boot done");
    spi_wr(SPI_CMD_WR, 196, 3, 1'b1);
    spi_rd(197, 3);
    cmp_all();
    $display("test spi wrapping burst done");
    spi_wr(8'h05, 10, 2, 1'b0);
    spi_rd(10, 2);
    $display("test spi unknown command done");
    repeat (6) begin
      a = (n_tests % 2) ? $urandom_range(131, 121) : $urandom_range(REG_COUNT - 1, 0);
      spi_wr(SPI_CMD_WR, a, 1, 1'b1);
      spi_rd(a, 1);
    end
    $display("test spi random access done");
    boot(2'h1);
    spi_wr(SPI_CMD_WR, 5, 2, 1'b0);
    cmp_all();
    $display("test spi ignored in two-wire slave mode done");
    i2c_cond(1'b0);
    i2c_tx(I2C_DEV_WR, ack);
    chk({7'h00, ack}, 8'h00);
    i2c_tx(8'(REG_COUNT - 1), ack);
    for (int k = 0; k < 2; k++) begin
      wd = 8'($urandom);
      i2c_tx(wd, ack);
      exp_regs[(REG_COUNT - 1 + k) % REG_COUNT] = wd;
    end
    i2c_cond(1'b1);
    i2c_cond(1'b0);
    i2c_tx(I2C_DEV_WR, ack);
    i2c_tx(8'(REG_COUNT - 1), ack);
    i2c_cond(1'b0);
    i2c_tx(I2C_DEV_RD, ack);
    chk({7'h00, ack}, 8'h00);
    i2c_rx(1'b0, rx);
    chk(rx, 8'(exp_regs[REG_COUNT - 1]));
    i2c_rx(1'b1, rx);
    chk(rx, 8'(exp_regs[0]));
    i2c_cond(1'b1);
    i2c_cond(1'b0);
    i2c_tx(8'h90, ack);
    chk({7'h00, ack}, 8'h01);
    i2c_cond(1'b1);
    cmp_all();
    $display("test two-wire slave burst and random read done");
    ee_load(ID);
    ee_load(~ID);
    summarize();
  end
endmodule : cfg_access_test

// [cfg_eeprom_model.sv]
`timescale 1ns/1ps
// ==========================================================
// serial eeprom on the two-wire bus, answers sequential reads
module cfg_eeprom_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] ptr;
  int         st;
  int         cnt;
  bit         first;
  bit         rd;
  initial begin
    sda_oe = 1'b0;
    st = 0;
    cnt = 0;
    ptr = 8'h00;
  end
  // start and stop only count while scl is high; own drive changes only with scl low
  always @(negedge sda) if (scl === 1'b1) begin
    st = 1;
    cnt = 0;
    first = 1;
    sda_oe = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    st = 0;
    sda_oe = 1'b0;
  end
  always @(posedge scl) begin
    if (st == 1 && cnt < 8) sh = {sh[6:0], sda};
    if (st == 2 && cnt == 8 && sda) st = 0;
    if (st != 0) cnt++;
  end
  always @(negedge scl) begin
    if (st == 1 && cnt == 8) begin
      if (first) begin
        st = (sh[7:1] == 7'h50) ? 1 : 0;
        sda_oe = (st == 1);
        rd = sh[0];
        first = 0;
      end else begin
        sda_oe = 1'b1;
        ptr = sh;
      end
    end else if (st == 1 && cnt == 9) begin
      sda_oe = 1'b0;
      cnt = 0;
      if (rd) st = 2;
    end else if (st == 2 && cnt == 9) begin
      cnt = 0;
      ptr++;
    end
    // released line floats to the pull-up, so a 1 bit is just no drive
    if (st == 2) sda_oe = (cnt < 8) ? ~mem[ptr][7-cnt] : 1'b0;
  end
endmodule : cfg_eeprom_model
